// [recog_pkg.sv]
// constants and carrier types for the adapter recognition handshake
// Contract
// [R1] adapter sends recognition notification within 300 ms of interface data response
// [R2] adapter that supports the method notifies support, then awaits acceptance
// [R3] adapter that cannot support the method notifies so, then gives up connecting
// [R4] on supported result, equipment sends acceptance within 300 ms, becomes unconfirmed
// [R5] on unsupported result, equipment sends nothing and awaits new data request
// [R6] acceptance within 300 ms moves adapter to unconfirmed
// [R7] no acceptance within 300 ms makes adapter resend interface data request
// [R8] requests flow adapter to equipment only; equipment only responds
// [R9] notification: header 0x02, type 0xFFFF, command 0x01, length 0x0001, result, check
// [R10] result codes 0x00,0x01,0x02,0x11,0x12; others reserved
// [R11] acceptance: header 0x02, type 0xFFFF, command 0x81, length 0x0000, check only
// [R12] acceptance echoes received frame number, or 0x00 without numbering
// [R13] stay unrecognized until recognition completes successfully
// [R14] adapter retries across transmission speeds until method confirmed
// [R15] each side provides recovery, such as repeating recognition, on failure
// [R16] detected communication failure returns side to unrecognized
// [R17] selected method starts no earlier than 500 ms after recognition
// [R18] frames: header, type, command, number, big-endian length, data, check octet
// [R19] requester numbers frames 0x01..0xFF; responses reuse request number
// [R20] check octet computed and verified by pluggable unit; bad frames dropped
// [R21] 300 ms and 500 ms timed by counters from a parameterised tick
package recog_pkg;
	// ========================================
	// frame fields
	localparam logic [7:0] HEADER_CODE = 8'h02;
	localparam logic [15:0] FRAME_TYPE = 16'hFFFF;
	localparam logic [7:0] CMD_NOTIFY = 8'h01;
	localparam logic [7:0] CMD_ACCEPT = 8'h81;
	localparam logic [15:0] LEN_NOTIFY = 16'h0001;
	localparam logic [15:0] LEN_ACCEPT = 16'h0000;
	localparam logic [7:0] SEQ_NONE = 8'h00;
	localparam int ACCEPT_OCTETS = 8;
	localparam logic [3:0] ACCEPT_LAST = 4'h7;
	// ========================================
	// result codes
	localparam logic [7:0] RES_SUPPORTED = 8'h00;
	localparam logic [7:0] RES_UNSUPPORTED = 8'h01;
	localparam logic [7:0] RES_SPEED_NG = 8'h02;
	localparam logic [7:0] RES_P2P_OK = 8'h11;
	localparam logic [7:0] RES_OBJ_OK = 8'h12;
	// ========================================
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int RESPONSE_TIMEOUT_MS = 300;
	localparam int SWITCH_MS = 500;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	// ========================================
	// types
	typedef enum logic [1:0] {
		ST_UNRECOG = 2'b00,
		ST_PARSE = 2'b01,
		ST_ANSWER = 2'b11,
		ST_UNCONF = 2'b10
	} recog_state_t;
	typedef enum logic [3:0] {
		RX_HDR = 4'h0, RX_TYPE_HI = 4'h1, RX_TYPE_LO = 4'h3, RX_CMD = 4'h2,
		RX_SEQ = 4'h6, RX_LEN_HI = 4'h7, RX_LEN_LO = 4'h5, RX_DATA = 4'h4,
		RX_CHECK = 4'hC
	} rx_phase_t;
	typedef struct packed {
		logic [7:0] seq;
		logic [7:0] result;
	} notify_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} octet_t;
endpackage

// [adapter_recognition_handshake.sv]
// equipment side of the adapter recognition handshake
`timescale 1ns/1ps
`default_nettype none
module adapter_recognition_handshake #(
	parameter int TICK_CYCLES = recog_pkg::TICK_CYCLES,
	parameter int TIMEOUT_TICKS = recog_pkg::RESPONSE_TIMEOUT_MS,
	parameter int SWITCH_TICKS = recog_pkg::SWITCH_MS,
	parameter bit USE_SEQ = 1'b1
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// received octets from the link receiver
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	// pluggable check unit: check over bytes seen so far
	input wire logic [7:0] rx_check_i,
	input wire logic [7:0] tx_check_i,
	// link status
	input wire logic link_fail_i,
	// transmit octets to the link transmitter
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	output logic tx_last_o,
	output logic tx_check_slot_o,
	// status
	output logic recognised_o,
	output logic method_ready_o,
	output logic [7:0] result_o,
	output logic notify_seen_o
);
	// refuse timing parameters that the counters cannot serve
	if (TICK_CYCLES < 1 || TIMEOUT_TICKS < 1 || SWITCH_TICKS < 1) begin : g_bad_timing
		$error("timing parameters must be positive");
	end
	// ========================================
	// input synchronisers for the asynchronous failure flag
	logic fail_s1_reg, fail_s2_reg;
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			fail_s1_reg <= 1'b0;
			fail_s2_reg <= 1'b0;
		end else begin
			fail_s1_reg <= link_fail_i;
			fail_s2_reg <= fail_s1_reg;
		end
	end
	// ========================================
	// tick divider
	logic [31:0] div_reg, div_next;
	logic tick;
	always_comb begin
		tick = (div_reg == 32'(TICK_CYCLES - 1)); // R21
		div_next = tick ? 32'h0 : div_reg + 32'h1;
	end
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i)
			div_reg <= 32'h0;
		else
			div_reg <= div_next;
	end
	// ========================================
	// frame receiver
	recog_pkg::rx_phase_t ph_reg, ph_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [15:0] len_reg, len_next;
	recog_pkg::notify_t nf_reg, nf_next;
	logic bad_reg, bad_next;
	logic frame_ok; // notification passed all checks except length
	always_comb begin
		ph_next = ph_reg;
		cmd_next = cmd_reg;
		len_next = len_reg;
		nf_next = nf_reg;
		bad_next = bad_reg;
		frame_ok = 1'b0;
		if (rx_valid_i) begin
			unique case (ph_reg)
				recog_pkg::RX_HDR: begin
					bad_next = 1'b0;
					if (rx_data_i == recog_pkg::HEADER_CODE) // R18
						ph_next = recog_pkg::RX_TYPE_HI;
				end
				recog_pkg::RX_TYPE_HI: begin
					bad_next = bad_reg | (rx_data_i != recog_pkg::FRAME_TYPE[15:8]);
					ph_next = recog_pkg::RX_TYPE_LO;
				end
				recog_pkg::RX_TYPE_LO: begin
					bad_next = bad_reg | (rx_data_i != recog_pkg::FRAME_TYPE[7:0]);
					ph_next = recog_pkg::RX_CMD;
				end
				recog_pkg::RX_CMD: begin
					cmd_next = rx_data_i;
					ph_next = recog_pkg::RX_SEQ;
				end
				recog_pkg::RX_SEQ: begin
					nf_next.seq = rx_data_i;
					ph_next = recog_pkg::RX_LEN_HI;
				end
				recog_pkg::RX_LEN_HI: begin
					len_next = {rx_data_i, 8'h00}; // R18
					ph_next = recog_pkg::RX_LEN_LO;
				end
				recog_pkg::RX_LEN_LO: begin
					len_next = {len_reg[15:8], rx_data_i};
					ph_next = ({len_reg[15:8], rx_data_i} == 16'h0000) ?
						recog_pkg::RX_CHECK : recog_pkg::RX_DATA;
				end
				recog_pkg::RX_DATA: begin
					if (len_reg == recog_pkg::LEN_NOTIFY)
						nf_next.result = rx_data_i;
					len_next = len_reg - 16'h1;
					if (len_reg == 16'h0001)
						ph_next = recog_pkg::RX_CHECK;
				end
				recog_pkg::RX_CHECK: begin
					ph_next = recog_pkg::RX_HDR;
					// R20 R9 R8: only a checked notification is acted on
					frame_ok = !bad_reg && rx_data_i == rx_check_i &&
						cmd_reg == recog_pkg::CMD_NOTIFY;
				end
				default: ph_next = recog_pkg::RX_HDR;
			endcase
		end
	end
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ph_reg <= recog_pkg::RX_HDR;
			cmd_reg <= 8'h00;
			len_reg <= 16'h0000;
			nf_reg <= '0;
			bad_reg <= 1'b0;
		end else begin
			ph_reg <= ph_next;
			cmd_reg <= cmd_next;
			len_reg <= len_next;
			nf_reg <= nf_next;
			bad_reg <= bad_next;
		end
	end
	// length of notification must be exactly one octet
	logic len_was_one_reg, len_was_one_next;
	always_comb begin
		len_was_one_next = len_was_one_reg;
		if (rx_valid_i && ph_reg == recog_pkg::RX_LEN_LO)
			len_was_one_next = ({len_reg[15:8], rx_data_i} == recog_pkg::LEN_NOTIFY); // R9
	end
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i)
			len_was_one_reg <= 1'b0;
		else
			len_was_one_reg <= len_was_one_next;
	end
	// ========================================
	// recognition state, answer sender and timers
	recog_pkg::recog_state_t st_reg, st_next;
	logic [3:0] idx_reg, idx_next;
	logic [31:0] tmr_reg, tmr_next;
	logic ready_reg, ready_next;
	logic [7:0] res_reg, res_next;
	logic seen_reg, seen_next;
	logic supported;
	logic [7:0] octet;
	always_comb begin
		// R10: supported codes; 0x01, 0x02 and reserved count as refusal
		supported = nf_reg.result == recog_pkg::RES_SUPPORTED ||
			nf_reg.result == recog_pkg::RES_P2P_OK ||
			nf_reg.result == recog_pkg::RES_OBJ_OK;
		st_next = st_reg;
		idx_next = idx_reg;
		tmr_next = tmr_reg;
		ready_next = ready_reg;
		res_next = res_reg;
		seen_next = 1'b0;
		unique case (st_reg)
			recog_pkg::ST_UNRECOG: begin
				ready_next = 1'b0; // R13
				if (frame_ok && len_was_one_reg) begin
					res_next = nf_next.result;
					seen_next = 1'b1;
					st_next = recog_pkg::ST_PARSE;
				end
			end
			recog_pkg::ST_PARSE: begin
				idx_next = 4'h0;
				tmr_next = 32'h0;
				// R5 R15: refusal sends nothing; wait for next request
				st_next = supported ? recog_pkg::ST_ANSWER : recog_pkg::ST_UNRECOG;
			end
			recog_pkg::ST_ANSWER: begin
				if (tick)
					tmr_next = tmr_reg + 32'h1;
				if (tmr_reg >= 32'(TIMEOUT_TICKS)) begin
					st_next = recog_pkg::ST_UNRECOG; // R4: window missed, recover
				end else if (tx_ready_i && tx_valid_o) begin
					idx_next = idx_reg + 4'h1;
					if (idx_reg == recog_pkg::ACCEPT_LAST) begin
						st_next = recog_pkg::ST_UNCONF; // R4
						tmr_next = 32'h0;
					end
				end
			end
			recog_pkg::ST_UNCONF: begin
				if (tick && !ready_reg)
					tmr_next = tmr_reg + 32'h1;
				// one extra tick absorbs the free-running divider's phase
				if (tmr_reg > 32'(SWITCH_TICKS))
					ready_next = 1'b1; // R17
				// a new notification restarts recognition
				if (frame_ok && len_was_one_reg) begin
					res_next = nf_next.result;
					seen_next = 1'b1;
					ready_next = 1'b0;
					st_next = recog_pkg::ST_PARSE;
				end
			end
		endcase
		if (fail_s2_reg) begin
			st_next = recog_pkg::ST_UNRECOG; // R16
			ready_next = 1'b0;
		end
		// answer octet at the index offered in the next cycle
		unique case (idx_next)
			4'h0: octet = recog_pkg::HEADER_CODE; // R11
			4'h1: octet = recog_pkg::FRAME_TYPE[15:8];
			4'h2: octet = recog_pkg::FRAME_TYPE[7:0];
			4'h3: octet = recog_pkg::CMD_ACCEPT;
			4'h4: octet = USE_SEQ ? nf_reg.seq : recog_pkg::SEQ_NONE; // R12
			4'h5: octet = recog_pkg::LEN_ACCEPT[15:8];
			4'h6: octet = recog_pkg::LEN_ACCEPT[7:0];
			default: octet = tx_check_i; // R20
		endcase
	end
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_reg <= recog_pkg::ST_UNRECOG;
			idx_reg <= 4'h0;
			tmr_reg <= 32'h0;
			ready_reg <= 1'b0;
			res_reg <= 8'h00;
			seen_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			idx_reg <= idx_next;
			tmr_reg <= tmr_next;
			ready_reg <= ready_next;
			res_reg <= res_next;
			seen_reg <= seen_next;
		end
	end
	// ========================================
	// registered outputs: offer loaded from the next index, held while stalled
	logic txv_reg, txl_reg, txc_reg, rec_reg;
	logic [7:0] txd_reg;
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			txv_reg <= 1'b0;
			txd_reg <= 8'h00;
			txl_reg <= 1'b0;
			txc_reg <= 1'b0;
			rec_reg <= 1'b0;
		end else begin
			txv_reg <= st_next == recog_pkg::ST_ANSWER;
			txd_reg <= octet; // R11
			txl_reg <= st_next == recog_pkg::ST_ANSWER && idx_next == recog_pkg::ACCEPT_LAST;
			txc_reg <= st_next == recog_pkg::ST_ANSWER && idx_next == recog_pkg::ACCEPT_LAST;
			rec_reg <= st_next == recog_pkg::ST_UNCONF;
		end
	end
	assign tx_valid_o = txv_reg;
	assign tx_data_o = txd_reg;
	assign tx_last_o = txl_reg;
	assign tx_check_slot_o = txc_reg;
	assign recognised_o = rec_reg;
	assign method_ready_o = ready_reg;
	assign result_o = res_reg;
	assign notify_seen_o = seen_reg;
endmodule
`default_nettype wire

// [recog_monitor.sv]
// checker for the acceptance answer path
`timescale 1ns/1ps
`default_nettype none
module recog_monitor #(
	parameter int TICK_CYCLES = 10,
	parameter int TIMEOUT_TICKS = 30,
	parameter int SWITCH_TICKS = 50
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// watched ports
	input wire logic [7:0] tx_check_i,
	input wire logic link_fail_i,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	input wire logic tx_last_o,
	input wire logic tx_check_slot_o,
	input wire logic recognised_o,
	input wire logic method_ready_o,
	input wire logic [7:0] result_o,
	input wire logic notify_seen_o
);
	localparam int AGE_MAX = (TIMEOUT_TICKS + 1) * TICK_CYCLES;
	localparam int TO_MIN = (TIMEOUT_TICKS - 1) * TICK_CYCLES;
	localparam int SW_MIN = SWITCH_TICKS * TICK_CYCLES;
	logic [2:0] idx_reg, idx_next;
	int age_reg, age_next, on_reg, on_next;
	logic ok;
	logic [7:0] exp;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// ========================================
	// octet position, answer age, recognised time
	always_comb begin
		idx_next = !tx_valid_o ? 3'h0 : idx_reg + 3'(tx_ready_i);
		age_next = notify_seen_o ? 0 : (age_reg > AGE_MAX ? age_reg : age_reg + 1);
		on_next = recognised_o ? on_reg + 1 : 0;
		ok = result_o inside {recog_pkg::RES_SUPPORTED, recog_pkg::RES_P2P_OK,
			recog_pkg::RES_OBJ_OK};
		case (idx_reg)
			3'h0: exp = recog_pkg::HEADER_CODE;
			3'h1, 3'h2: exp = 8'hFF;
			3'h3: exp = recog_pkg::CMD_ACCEPT;
			3'h7: exp = tx_check_i;
			default: exp = 8'h00;
		endcase
	end
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			idx_reg <= 3'h0;
			age_reg <= AGE_MAX + 1;
			on_reg <= 0;
		end else begin
			idx_reg <= idx_next;
			age_reg <= age_next;
			on_reg <= on_next;
		end
	end
	// ========================================
	// assertions
	a_accept_fields: assert property (
		tx_valid_o && idx_reg != 3'h4 |-> tx_data_o == exp) else $error("answer octet wrong");
	a_check_slot: assert property (
		tx_valid_o |-> tx_last_o == (idx_reg == 3'h7) && tx_check_slot_o == tx_last_o)
		else $error("check slot misplaced");
	a_hold_offer: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o ? $stable(tx_data_o) : age_reg >= TO_MIN)
		else $error("offer not held");
	a_recog_cause: assert property (
		$rose(recognised_o) |-> $past(tx_valid_o && tx_ready_i && tx_last_o))
		else $error("recognised without answer");
	a_answer_soon: assert property (
		notify_seen_o ##1 ok |-> ##[0:3] tx_valid_o) else $error("answer late");
	a_refuse_bad: assert property (
		notify_seen_o ##1 !ok |-> ##3 (!tx_valid_o && !recognised_o) [*6])
		else $error("refused result answered");
	a_answer_age: assert property (
		tx_valid_o |-> age_reg <= AGE_MAX) else $error("answer outside window");
	a_fail_drop: assert property (
		link_fail_i [*5] |-> !recognised_o && !method_ready_o && !tx_valid_o)
		else $error("failure not dropping state");
	a_switch_wait: assert property (
		method_ready_o |-> recognised_o && on_reg >= SW_MIN) else $error("method ready early");
	// main scenarios
	c_answered: cover property (tx_valid_o && tx_ready_i && tx_last_o);
	c_refused: cover property (notify_seen_o ##1 !ok);
	c_ready: cover property ($rose(method_ready_o));
endmodule
`default_nettype wire

// [adapter_model.sv]
// adapter-side model: sends notifications, takes answer octets
`timescale 1ns/1ps
`default_nettype none
module adapter_model (
	// clock and pacing: 0 prompt, 1 slow, 2 stalled
	input wire logic sys_clk_i,
	input wire logic [1:0] mode_i,
	// link toward the equipment
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o
);
	logic [7:0] got [0:7];
	int n = 0;
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b0;
	end
	// ready pacing, slow mode alternates
	always @(negedge sys_clk_i) begin
		tx_ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && !tx_ready_o);
	end
	// answer capture on handshake
	always @(posedge sys_clk_i) begin
		if (tx_valid_i && tx_ready_o && n < 8) begin
			got[n] = tx_data_i;
			n++;
		end
	end
	// one request frame, header first, length big-endian
	task automatic notify(input logic [7:0] cmd, input logic [7:0] seq,
		input logic [7:0] res, input logic [7:0] chk);
		logic [71:0] f;
		f = {recog_pkg::HEADER_CODE, recog_pkg::FRAME_TYPE, cmd, seq,
			recog_pkg::LEN_NOTIFY, res, chk};
		for (int i = 8; i >= 0; i--) begin
			@(negedge sys_clk_i);
			rx_valid_o = 1'b1;
			rx_data_o = f[i*8 +: 8];
		end
		@(negedge sys_clk_i);
		rx_valid_o = 1'b0;
		rx_data_o = ~rx_data_o;
	endtask
endmodule
`default_nettype wire

// [adapter_recognition_handshake_bench.sv]
// self-checking bench for the recognition handshake
`timescale 1ns/1ps
`default_nettype none
module adapter_recognition_handshake_bench;
	localparam int TK = 10;
	localparam int TO = 30;
	localparam int SW = 50;
	localparam logic [7:0] GOOD = 8'h5A;
	typedef struct packed {logic [7:0] seq; logic [7:0] res; logic ans;} row_t;
	row_t rows [0:5] = '{'{8'h01, 8'h00, 1'b1}, '{8'h7F, 8'h11, 1'b1}, '{8'hFF, 8'h12, 1'b1},
		'{8'h02, 8'h01, 1'b0}, '{8'h03, 8'h02, 1'b0}, '{8'h04, 8'h33, 1'b0}};
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic link_fail_i = 1'b0;
	logic [1:0] mode = 2'h0;
	logic rx_valid, tx_valid, tx_ready, recog, mready, seen;
	logic [7:0] rx_data, tx_data, result;
	int fail_count = 0;
	int checks = 0;
	int seen_n = 0;
	adapter_recognition_handshake #(.TICK_CYCLES(TK), .TIMEOUT_TICKS(TO), .SWITCH_TICKS(SW))
		i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .rx_valid_i(rx_valid),
		.rx_data_i(rx_data), .rx_check_i(GOOD), .tx_check_i(8'hC3), .link_fail_i(link_fail_i),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready), .tx_last_o(),
		.tx_check_slot_o(), .recognised_o(recog), .method_ready_o(mready),
		.result_o(result), .notify_seen_o(seen));
	adapter_model i_peer (.sys_clk_i(sys_clk_i), .mode_i(mode), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (seen === 1'b1) seen_n++;
	// compare and count
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// send one frame, then let it settle
	task automatic frame(input logic [7:0] cmd, input logic [7:0] seq, input logic [7:0] res,
		input logic [7:0] c, input int cyc);
		i_peer.n = 0;
		i_peer.notify(cmd, seq, res, c);
		repeat (cyc) @(negedge sys_clk_i);
	endtask
	task automatic conclude;
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#50000;
		fail_count++;
		$display("watchdog expired");
		conclude();
	end
	// ========================================
	// table of result codes, then awkward cases
	initial begin
		int s;
		logic [63:0] e;
		repeat (2) @(negedge sys_clk_i);
		chk("outputs in reset", 8'h00, {tx_valid, recog, mready, seen, result[3:0]});
		reset_i = 1'b0;
		$display("test done: reset");
		foreach (rows[i]) begin
			s = seen_n;
			frame(recog_pkg::CMD_NOTIFY, rows[i].seq, rows[i].res, GOOD, 40);
			chk("notify seen", 8'(s + 1), 8'(seen_n));
			chk("result", rows[i].res, result);
			chk("answer count", rows[i].ans ? 8'h08 : 8'h00, 8'(i_peer.n));
			chk("recognised", {7'h0, rows[i].ans}, {7'h0, recog});
			e = {recog_pkg::HEADER_CODE, recog_pkg::FRAME_TYPE, recog_pkg::CMD_ACCEPT,
				rows[i].seq, recog_pkg::LEN_ACCEPT, 8'hC3};
			for (int k = 0; k < 8 && rows[i].ans; k++)
				chk("answer octet", e[63-8*k -: 8], i_peer.got[k]);
		end
		$display("test done: result table");
		s = seen_n;
		frame(recog_pkg::CMD_NOTIFY, 8'h05, 8'h00, ~GOOD, 40);
		frame(recog_pkg::CMD_ACCEPT, 8'h06, 8'h00, GOOD, 40);
		chk("bad frames seen", 8'(s), 8'(seen_n));
		chk("bad frames answered", 8'h00, 8'(i_peer.n));
		$display("test done: refused frames");
		mode = 2'h1;
		frame(recog_pkg::CMD_NOTIFY, 8'h09, 8'h12, GOOD, 60);
		chk("slow answer count", 8'h08, 8'(i_peer.n));
		chk("ready too soon", 8'h02, {6'h0, recog, mready});
		repeat (SW * TK) @(negedge sys_clk_i);
		chk("method ready", 8'h03, {6'h0, recog, mready});
		$display("test done: switch-over");
		link_fail_i = 1'b1;
		repeat (8) @(negedge sys_clk_i);
		chk("state after failure", 8'h00, {6'h0, recog, mready});
		link_fail_i = 1'b0;
		$display("test done: link failure");
		mode = 2'h2;
		frame(recog_pkg::CMD_NOTIFY, 8'h0A, 8'h11, GOOD, (TO + 2) * TK);
		chk("stalled answer", 8'h00, {6'h0, tx_valid, recog});
		mode = 2'h0;
		repeat (20) @(negedge sys_clk_i);
		chk("stale answer", 8'h00, 8'(i_peer.n));
		frame(recog_pkg::CMD_NOTIFY, 8'h0B, 8'h00, GOOD, 40);
		chk("retry answered", 8'h08, 8'(i_peer.n));
		chk("retry recognised", 8'h01, {7'h0, recog});
		$display("test done: answer timeout");
		reset_i = 1'b1;
		@(negedge sys_clk_i);
		chk("outputs after reset", 8'h00, {tx_valid, recog, mready, seen, result[3:0]});
		reset_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		chk("idle after reset", 8'h00, {6'h0, tx_valid, recog});
		$display("test done: mid-run reset");
		conclude();
	end
endmodule
bind adapter_recognition_handshake recog_monitor #(.TICK_CYCLES(TICK_CYCLES),
	.TIMEOUT_TICKS(TIMEOUT_TICKS), .SWITCH_TICKS(SWITCH_TICKS)) i_mon (.sys_clk_i(sys_clk_i),
	.reset_i(reset_i), .tx_check_i(tx_check_i), .link_fail_i(link_fail_i),
	.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
	.tx_last_o(tx_last_o), .tx_check_slot_o(tx_check_slot_o), .recognised_o(recognised_o),
	.method_ready_o(method_ready_o), .result_o(result_o), .notify_seen_o(notify_seen_o));
`default_nettype wire
